// >>> hw/mealy_sequencer.sv
// Programmable Mealy sequencer: AND/OR arrays, state and output registers,
// APB programming port. Assumes inputs synchronous to clk and a tristate
// pad outside driven from f_out and f_oe.
//
// Summary of operation
// - Up to 48 product terms over 16 inputs and 6 fed-back state bits.
// - Each term tests each variable true, false or not at all.
// - State and output registers change only on a rising clock edge.
// - Six state and eight output set/reset flip-flops with preset.
// - Power-on reset sets every state and output register bit to one.
// - Optional complement variable enters the terms.
// - Control pin is either preset or active-low output enable.
// - Preset forces all bits to one, blocks clocking, outputs high.
// - After preset falls, one edge is skipped before clocking resumes.
// - Output-enable mode: low drives outputs, high floats, registers kept.
// - Normally the outputs show the output register.
// - Diagnostic level shows state bits on outputs 0-5, ones on 6-7.
// - Set/reset: hold, clear, set; both high is indeterminate (the code holds the bit when both are high).
// - An intact input or state pair inhibits its term.
// - Unprogrammed: preset mode, all terms and commands disabled.
// - Complement use passes the inputs twice through the AND array.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module mealy_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [seq_pkg::NUM_IN-1:0] logic_in,
  input wire logic diag_level,
  input wire logic preset_or_output_enable,
  output logic [seq_pkg::NUM_OUT-1:0] f_out,
  output logic f_oe
);

  // ----------------------------------------------------------------------
  // State and array wiring
  // ----------------------------------------------------------------------
  seq_pkg::seq_state_t s_q;
  seq_pkg::seq_state_t s_d;

  logic [seq_pkg::NUM_VARS-1:0] vars;
  logic [seq_pkg::NUM_TERMS-1:0] term_p1;
  logic [seq_pkg::NUM_TERMS-1:0] term_full;
  logic [seq_pkg::NUM_TERMS-1:0] conn_mask;
  logic c_var;
  logic preset_active;
  logic clock_ok;
  logic [seq_pkg::NUM_STATE-1:0] st_set;
  logic [seq_pkg::NUM_STATE-1:0] st_rst;
  logic [seq_pkg::NUM_OUT-1:0] out_set;
  logic [seq_pkg::NUM_OUT-1:0] out_rst;
  logic apb_access;
  logic apb_done;
  logic map_term;
  logic [5:0] term_idx;
  logic [1:0] word_sel;

  // Inputs in the low bits, state fed back above them
  assign vars = {s_q.state, logic_in};

  // ----------------------------------------------------------------------
  // AND array, one gate per term
  // ----------------------------------------------------------------------
  generate
    for (genvar k = 0; k < seq_pkg::NUM_TERMS; k++) begin : g_term
      product_term u_term (
        .vars(vars),
        .c_var(c_var),
        .and_in(s_q.and_in[k]),
        .and_pc(s_q.and_pc[k]),
        .t_pass1(term_p1[k]),
        .t_full(term_full[k])
      );
      assign conn_mask[k] = (s_q.and_pc[k][seq_pkg::PC_CONN_LSB +: 2] == seq_pkg::PAIR_TRUE);
    end
  endgenerate

  // Complement gate from the first pass; avoids a combinational loop
  // at the cost of a second pass through the array
  assign c_var = ~|(term_p1 & conn_mask);

  // ----------------------------------------------------------------------
  // OR array: set/reset commands per flip-flop
  // ----------------------------------------------------------------------
  always_comb begin
    st_set = '0;
    st_rst = '0;
    out_set = '0;
    out_rst = '0;
    for (int k = 0; k < seq_pkg::NUM_TERMS; k++) begin
      for (int j = 0; j < seq_pkg::NUM_STATE; j++) begin
        st_set[j] = st_set[j] |
          (term_full[k] & s_q.or_cmd[k][seq_pkg::OR_N_LSB+2*j+seq_pkg::CMD_SET_BIT]);
        st_rst[j] = st_rst[j] |
          (term_full[k] & s_q.or_cmd[k][seq_pkg::OR_N_LSB+2*j+seq_pkg::CMD_RESET_BIT]);
      end
      for (int j = 0; j < seq_pkg::NUM_OUT; j++) begin
        out_set[j] = out_set[j] |
          (term_full[k] & s_q.or_cmd[k][seq_pkg::OR_F_LSB+2*j+seq_pkg::CMD_SET_BIT]);
        out_rst[j] = out_rst[j] |
          (term_full[k] & s_q.or_cmd[k][seq_pkg::OR_F_LSB+2*j+seq_pkg::CMD_RESET_BIT]);
      end
    end
  end

  // Set/reset flip-flop; both high kept as hold
  function automatic logic sr_next(input logic q, input logic set, input logic clr);
    case ({set, clr})
      2'b10: sr_next = 1'b1;
      2'b01: sr_next = 1'b0;
      default: sr_next = q;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Control pin and clock gating
  // ----------------------------------------------------------------------
  // Pin means preset only when not in output-enable mode
  assign preset_active = ~s_q.oe_mode & preset_or_output_enable;
  assign clock_ok = ~preset_active & ~s_q.hold;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign apb_access = psel & penable & ~s_q.pready;
  assign apb_done = psel & penable & s_q.pready;
  assign term_idx = paddr[seq_pkg::TERM_IDX_LSB +: 6];
  assign word_sel = paddr[seq_pkg::WORD_LSB +: 2];
  assign map_term = (paddr[11:10] == seq_pkg::TERM_REGION) &&
                    (term_idx < 6'(seq_pkg::NUM_TERMS)) &&
                    (word_sel != 2'h3) && (paddr[1:0] == 2'h0);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Registers: preset forces ones, else set/reset commands
    if (preset_active) begin
      s_d.state = seq_pkg::STATE_RESET;
      s_d.outreg = seq_pkg::OUT_RESET;
    end else if (clock_ok) begin
      for (int j = 0; j < seq_pkg::NUM_STATE; j++) begin
        s_d.state[j] = sr_next(s_q.state[j], st_set[j], st_rst[j]);
      end
      for (int j = 0; j < seq_pkg::NUM_OUT; j++) begin
        s_d.outreg[j] = sr_next(s_q.outreg[j], out_set[j], out_rst[j]);
      end
    end
    // First edge after preset release is swallowed
    s_d.hold = preset_active;

    // Output pins follow the registers as they will be after this edge
    if (diag_level) begin
      s_d.f = {2'b11, s_d.state};
    end else begin
      s_d.f = s_d.outreg;
    end
    // Float only in output-enable mode with the pin high
    s_d.f_oe = ~(s_q.oe_mode & preset_or_output_enable);

    // Bus answer one wait state after the access phase opens
    s_d.pready = apb_access;
    if (apb_access) begin
      s_d.prdata = seq_pkg::WORD_RESET;
      s_d.pslverr = 1'b0;
      if (paddr == seq_pkg::CTRL_ADDR) begin
        s_d.prdata[seq_pkg::CTRL_OE_BIT] = s_q.oe_mode;
      end else if (paddr == seq_pkg::STATUS_ADDR) begin
        s_d.prdata[seq_pkg::STAT_STATE_LSB +: seq_pkg::NUM_STATE] = s_q.state;
        s_d.prdata[seq_pkg::STAT_C_BIT] = c_var;
        s_d.prdata[seq_pkg::STAT_HOLD_BIT] = s_q.hold;
        s_d.prdata[seq_pkg::STAT_OUT_LSB +: seq_pkg::NUM_OUT] = s_q.outreg;
      end else if (map_term && word_sel == seq_pkg::WORD_AND_IN) begin
        s_d.prdata = s_q.and_in[term_idx];
      end else if (map_term && word_sel == seq_pkg::WORD_AND_PC) begin
        s_d.prdata[15:0] = s_q.and_pc[term_idx];
      end else if (map_term) begin
        s_d.prdata[27:0] = s_q.or_cmd[term_idx];
      end else begin
        s_d.pslverr = 1'b1;
      end
    end else if (apb_done) begin
      s_d.pslverr = 1'b0;
    end

    // Writes take effect at the completing edge; status is read-only
    if (apb_done && pwrite) begin
      if (paddr == seq_pkg::CTRL_ADDR) begin
        s_d.oe_mode = pwdata[seq_pkg::CTRL_OE_BIT];
      end else if (map_term && word_sel == seq_pkg::WORD_AND_IN) begin
        s_d.and_in[term_idx] = pwdata;
      end else if (map_term && word_sel == seq_pkg::WORD_AND_PC) begin
        s_d.and_pc[term_idx] = pwdata[15:0];
      end else if (map_term) begin
        s_d.or_cmd[term_idx] = pwdata[27:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register stage
  // ----------------------------------------------------------------------
  // Reset leaves a blank array: preset mode, no terms, no commands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.and_in <= '0;
      s_q.and_pc <= '0;
      s_q.or_cmd <= '0;
      s_q.oe_mode <= seq_pkg::CTRL_OE_RESET;
      s_q.state <= seq_pkg::STATE_RESET;
      s_q.outreg <= seq_pkg::OUT_RESET;
      s_q.hold <= 1'b0;
      s_q.f <= seq_pkg::OUT_RESET;
      s_q.f_oe <= 1'b1;
      s_q.prdata <= seq_pkg::WORD_RESET;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign f_out = s_q.f;
  assign f_oe = s_q.f_oe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Checked without the disable so the reset window itself is seen
  chk_power_on_ones: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> (s_q.state == seq_pkg::STATE_RESET && s_q.outreg == seq_pkg::OUT_RESET))
    else $error("registers not all ones under reset");

  chk_preset_forces: assert property (preset_active |=>
    (s_q.state == seq_pkg::STATE_RESET && s_q.outreg == seq_pkg::OUT_RESET && f_oe))
    else $error("preset did not force ones");

  chk_preset_outputs: assert property (preset_active && !diag_level |=> f_out == 8'hff)
    else $error("outputs not high under preset");

  chk_resume_skip: assert property ($fell(preset_active) |->
    s_q.hold ##1 ($stable(s_q.state) && $stable(s_q.outreg) && !s_q.hold))
    else $error("edge after preset release not skipped");

  chk_oe_float: assert property (s_q.oe_mode && preset_or_output_enable |=>
    (!f_oe && ($stable(s_q.outreg) || $past(clock_ok))))
    else $error("outputs not floated in output-enable mode");

  chk_oe_drive: assert property (s_q.oe_mode && !preset_or_output_enable |=> f_oe)
    else $error("outputs not driven with enable low");

  chk_out_follow: assert property (!diag_level |=> f_out == s_q.outreg)
    else $error("outputs do not show output register");

  chk_diag_view: assert property (diag_level |=> f_out == {2'b11, s_q.state})
    else $error("diagnostic view wrong");

  chk_sr_set: assert property (clock_ok && st_set[0] && !st_rst[0] |=> s_q.state[0])
    else $error("set command did not set state bit");

  chk_sr_clear: assert property (clock_ok && !st_set[0] && st_rst[0] |=> !s_q.state[0])
    else $error("reset command did not clear state bit");

  chk_sr_hold: assert property (!st_set[5] && !st_rst[5] && !preset_active
    |=> $stable(s_q.state[5]))
    else $error("state bit changed without command");

  chk_intact_inhibit: assert property ((s_q.and_in[0][1:0] == seq_pkg::PAIR_INTACT)
    |-> !term_full[0] && !term_p1[0])
    else $error("term with intact pair is active");

  chk_comp_gate: assert property ((|(term_p1 & conn_mask)) |-> !c_var)
    else $error("complement high with connected term active");

  chk_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("bus access not answered in one wait state");

  // Output bits follow the same set/reset table as the state bits
  chk_out_sr_set: assert property (clock_ok && out_set[7] && !out_rst[7]
    |=> s_q.outreg[7])
    else $error("set command did not set output bit");

  chk_out_sr_clear: assert property (clock_ok && !out_set[7] && out_rst[7]
    |=> !s_q.outreg[7])
    else $error("reset command did not clear output bit");

  // The swallowed edge must leave both registers untouched
  chk_hold_after_preset: assert property (preset_active |=> s_q.hold)
    else $error("hold not raised by preset");

  chk_hold_frozen: assert property (s_q.hold |=>
    ($stable(s_q.state) && $stable(s_q.outreg)))
    else $error("registers moved on the swallowed edge");

  // Complement is the inverse of the connected first-pass terms
  chk_comp_high: assert property (!(|(term_p1 & conn_mask)) |-> c_var)
    else $error("complement low with no connected term active");

  // Blank array: no term can fire, complement idles high
  chk_blank_array: assert property ((s_q.and_in == '0 && s_q.and_pc == '0)
    |-> (term_full == '0 && c_var))
    else $error("blank array produced an active term");

  // State pairs inhibit just like input pairs
  chk_state_pair_inhibit: assert property
    ((s_q.and_pc[1][seq_pkg::PC_P_LSB +: 2] == seq_pkg::PAIR_INTACT) |-> !term_full[1])
    else $error("term with intact state pair is active");

  // Upper address regions hold nothing, so every access there errs
  chk_apb_error: assert property (psel && penable && !pready && paddr[11:10] != 2'h0
    |=> pready && pslverr)
    else $error("unmapped access answered without error");

  // Ready is a single-cycle pulse; a second one would double a write
  chk_apb_pulse: assert property (pready |=> !pready)
    else $error("ready held for more than one cycle");

  cov_preset_resume: cover property (preset_active ##1 !preset_active ##1 s_q.hold == 1'b0);
  cov_diag: cover property (diag_level && s_q.state != seq_pkg::STATE_RESET);
  cov_oe_float: cover property (s_q.oe_mode ##1 !f_oe);
  cov_state_move: cover property (clock_ok && |(term_full & ~conn_mask) ##1 $changed(s_q.state));
  cov_comp_toggle: cover property (!c_var ##1 c_var);

endmodule // mealy_sequencer

`default_nettype wire

// >>> hw/product_term.sv
// One AND-array gate: tests every variable through its link pair.
// Assumes the complement variable arrives from the enclosing sequencer.
`timescale 1ns/100ps
`default_nettype none

module product_term (
  input wire logic [seq_pkg::NUM_VARS-1:0] vars,
  input wire logic c_var,
  input wire logic [31:0] and_in,
  input wire logic [15:0] and_pc,
  output logic t_pass1,
  output logic t_full
);

  // ----------------------------------------------------------------------
  // Link-pair evaluation
  // ----------------------------------------------------------------------
  // Intact pair inhibits the gate
  function automatic logic pair_ok(input logic [1:0] pair, input logic v);
    case (pair)
      seq_pkg::PAIR_TRUE: pair_ok = v;
      seq_pkg::PAIR_FALSE: pair_ok = ~v;
      seq_pkg::PAIR_DONT: pair_ok = 1'b1;
      default: pair_ok = 1'b0;
    endcase
  endfunction

  logic [seq_pkg::NUM_VARS-1:0] ok;
  logic [1:0] c_pair;

  // Input and state pairs, true/false/don't care or inhibit
  always_comb begin
    for (int i = 0; i < seq_pkg::NUM_IN; i++) begin
      ok[i] = pair_ok(and_in[2*i +: 2], vars[i]);
    end
    for (int j = 0; j < seq_pkg::NUM_STATE; j++) begin
      ok[seq_pkg::NUM_IN+j] = pair_ok(and_pc[seq_pkg::PC_P_LSB+2*j +: 2],
                                     vars[seq_pkg::NUM_IN+j]);
    end
  end

  assign c_pair = and_pc[seq_pkg::PC_C_LSB +: 2];
  // First pass ignores C, second pass tests it
  assign t_pass1 = &ok;
  // Intact C pair is treated as don't care, C being optional
  assign t_full = t_pass1 & ((c_pair == seq_pkg::PAIR_INTACT) | pair_ok(c_pair, c_var));

endmodule // product_term

`default_nettype wire

// >>> hw/seq_pkg.sv
// Constants, link-pair codes, register map and state type for the sequencer.
// Assumes a single 250 MHz clock domain and an APB master for programming.
package seq_pkg;

  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int NUM_TERMS = 48;
  localparam int NUM_IN = 16;
  localparam int NUM_STATE = 6;
  localparam int NUM_OUT = 8;
  localparam int NUM_VARS = NUM_IN + NUM_STATE;

  // ----------------------------------------------------------------------
  // Link-pair codes (AND array and complement connection)
  // ----------------------------------------------------------------------
  localparam logic [1:0] PAIR_INTACT = 2'h0;
  localparam logic [1:0] PAIR_TRUE = 2'h1;
  localparam logic [1:0] PAIR_FALSE = 2'h2;
  localparam logic [1:0] PAIR_DONT = 2'h3;
  // Bit 0 of an OR-array pair issues set, bit 1 issues reset
  localparam int CMD_SET_BIT = 0;
  localparam int CMD_RESET_BIT = 1;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR = 12'h300;
  localparam logic [11:0] STATUS_ADDR = 12'h304;
  localparam logic [1:0] TERM_REGION = 2'h0;
  localparam int TERM_IDX_LSB = 4;
  localparam int WORD_LSB = 2;
  localparam logic [1:0] WORD_AND_IN = 2'h0;
  localparam logic [1:0] WORD_AND_PC = 2'h1;
  localparam logic [1:0] WORD_OR = 2'h2;

  // Field positions in the per-term, control and status words
  localparam int PC_P_LSB = 0;
  localparam int PC_C_LSB = 12;
  localparam int PC_CONN_LSB = 14;
  localparam int OR_N_LSB = 0;
  localparam int OR_F_LSB = 12;
  localparam int CTRL_OE_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_C_BIT = 6;
  localparam int STAT_HOLD_BIT = 7;
  localparam int STAT_OUT_LSB = 8;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [NUM_STATE-1:0] STATE_RESET = 6'h3f;
  localparam logic [NUM_OUT-1:0] OUT_RESET = 8'hff;
  localparam logic CTRL_OE_RESET = 1'b0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Complete state of the sequencer core
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_TERMS-1:0][31:0] and_in;
    logic [NUM_TERMS-1:0][15:0] and_pc;
    logic [NUM_TERMS-1:0][27:0] or_cmd;
    logic oe_mode;
    logic [NUM_STATE-1:0] state;
    logic [NUM_OUT-1:0] outreg;
    logic hold;
    logic [NUM_OUT-1:0] f;
    logic f_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } seq_state_t;

endpackage

// >>> tb/seq_pad_model.sv
// Pad and board model at the sequencer's output pins.
// Assumes f_out and f_oe come straight from the design's registers.
`timescale 1ns/100ps
`default_nettype none

module seq_pad_model (
  input wire logic clk,
  input wire logic [7:0] f_out,
  input wire logic f_oe,
  output logic [7:0] pad,
  output logic driven
);
  logic [7:0] last_q;

  // -----------------------------------------------------------------
  // Pin resolution
  // -----------------------------------------------------------------
  // No pull on the pins: a floating pad shows the inverse of its last value
  always_ff @(posedge clk) begin
    if (f_oe) begin
      last_q <= f_out;
    end
  end
  assign pad = f_oe ? f_out : ~last_q;
  assign driven = f_oe;
endmodule // seq_pad_model

`default_nettype wire

// >>> tb/tb_programmable_mealy_sequencer.sv
// Self-checking bench for the programmable Mealy sequencer.
// Assumes the design package and the pad model are compiled first.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %0t: value mismatch got %h exp %h", $time, got, exp); end end

module tb_programmable_mealy_sequencer;
  logic clk, rst, psel, penable, pwrite, pslverr, pready, diag_level, pin, f_oe, driven;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] logic_in;
  logic [7:0] f_out, pad;
  logic er;
  int err_total, total_checks;

  // -----------------------------------------------------------------
  // Instances, clock and reset
  // -----------------------------------------------------------------
  mealy_sequencer i_mealy_sequencer (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .logic_in(logic_in), .diag_level(diag_level),
    .preset_or_output_enable(pin), .f_out(f_out), .f_oe(f_oe));
  seq_pad_model i_seq_pad_model (.clk(clk), .f_out(f_out), .f_oe(f_oe), .pad(pad),
    .driven(driven));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic results();
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // APB transfer; waits on pready with a bound, never on a fixed latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 20);
    if (!pready) begin
      err_total++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    `CHK(f_out, 8'hff)
    `CHK(f_oe, 1'b1)
    apb(1'b0, seq_pkg::STATUS_ADDR, 32'h0000_0000);
    `CHK({rd[15:8], rd[5:0]}, 14'h3fff)
    apb(1'b0, seq_pkg::CTRL_ADDR, 32'h0000_0000);
    `CHK(rd[0], 1'b0)
    apb(1'b0, 12'h400, 32'h0000_0000);
    `CHK({er, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
    apb(1'b1, seq_pkg::STATUS_ADDR, 32'h0000_0000);
    `CHK(er, 1'b0)
  endtask

  // Term 0: I1 true, rest don't care; resets P0 and F7
  task automatic t_run();
    apb(1'b1, 12'h000, 32'hffff_fff7);
    apb(1'b1, 12'h004, 32'h0000_3fff);
    apb(1'b1, 12'h008, 32'h0800_0002);
    edges(3);
    `CHK(f_out, 8'hff)
    @(posedge clk);
    logic_in <= 16'h0002;
    edges(2);
    `CHK(f_out, 8'h7f)
    apb(1'b0, seq_pkg::STATUS_ADDR, 32'h0000_0000);
    `CHK({rd[15:8], rd[5:0]}, {8'h7f, 6'h3e})
  endtask

  task automatic t_diag();
    diag_level <= 1'b1;
    edges(2);
    `CHK(f_out, 8'hfe)
    @(posedge clk);
    diag_level <= 1'b0;
    edges(2);
    `CHK(f_out, 8'h7f)
  endtask

  // Preset blocks clocking; one edge skipped after release
  task automatic t_preset();
    @(posedge clk);
    pin <= 1'b1;
    edges(2);
    `CHK(f_out, 8'hff)
    @(posedge clk);
    pin <= 1'b0;
    edges(1);
    `CHK(f_out, 8'hff)
    edges(1);
    `CHK(f_out, 8'h7f)
  endtask

  task automatic t_oe();
    apb(1'b1, seq_pkg::CTRL_ADDR, 32'h0000_0001);
    pin <= 1'b1;
    edges(2);
    `CHK({f_oe, driven}, 2'b00)
    `CHK(pad, 8'h80)
    apb(1'b0, seq_pkg::STATUS_ADDR, 32'h0000_0000);
    `CHK(rd[15:8], 8'h7f)
    pin <= 1'b0;
    edges(2);
    `CHK(pad, 8'h7f)
  endtask

  // Term 1 on the complement array, active while I2 is high; term 2 needs C high
  task automatic t_compl();
    apb(1'b1, 12'h010, 32'hffff_ffdf);
    apb(1'b1, 12'h014, 32'h0000_7fff);
    apb(1'b0, seq_pkg::STATUS_ADDR, 32'h0000_0000);
    `CHK(rd[6], 1'b1)
    logic_in <= 16'h0006;
    edges(2);
    apb(1'b0, seq_pkg::STATUS_ADDR, 32'h0000_0000);
    `CHK(rd[6], 1'b0)
    apb(1'b1, 12'h020, 32'hffff_ffff);
    apb(1'b1, 12'h024, 32'h0000_1fff);
    apb(1'b1, 12'h028, 32'h0200_0000);
    edges(2);
    `CHK(f_out, 8'h7f)
    @(posedge clk);
    logic_in <= 16'h0002;
    edges(2);
    `CHK(f_out, 8'h3f)
  endtask

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    logic_in = 16'h0000;
    diag_level = 1'b0;
    pin = 1'b0;
    err_total = 0;
    total_checks = 0;
    // Blank array after reset, so no test pattern needs removing
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    edges(1);
    t_reset();
    t_run();
    t_diag();
    t_preset();
    t_oe();
    t_compl();
    results();
  end
endmodule // tb_programmable_mealy_sequencer

`default_nettype wire
